// File: verilog/mpc_pkg.sv
// constants shared by the port pin control block
package mpc_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_PORT_IN   = 8'h00; // pin levels of all ports
  localparam logic [7:0] OFS_LATCH     = 8'h04; // output latches p2,p3,p5,p6,p7
  localparam logic [7:0] OFS_MODE      = 8'h08; // direction controls
  localparam logic [7:0] OFS_PULLUP    = 8'h0C; // pullup_select_group_a
  localparam logic [7:0] OFS_ALT       = 8'h10; // alternate function enables
  localparam logic [7:0] OFS_EDGE      = 8'h14; // edge mode selects
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h18; // sticky events, write one clears
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h1C; // interrupt mask

  // field positions of the port input word
  localparam int P0_LSB = 0;
  localparam int P1_LSB = 4;
  localparam int P2_LSB = 8;
  localparam int P3_LSB = 12;
  localparam int P5_LSB = 16;
  localparam int P6_LSB = 20;
  localparam int P7_LSB = 24;

  // mode register fields
  localparam int MODE_P2_BIT  = 0;
  localparam int MODE_P5_BIT  = 1;
  localparam int MODE_P7_BIT  = 2;
  localparam int MODE_P67_BIT = 3;
  localparam int MODE_P3_LSB  = 4;
  localparam int MODE_P6_LSB  = 8;

  // pullup register fields
  localparam int PU_P0_BIT = 0;
  localparam int PU_P1_BIT = 1;
  localparam int PU_P2_BIT = 2;
  localparam int PU_P3_BIT = 3;
  localparam int PU_P6_BIT = 4;
  localparam int PU_P7_BIT = 5;

  // alternate function enables
  localparam int ALT_SQA_BIT  = 0;
  localparam int ALT_SQB_BIT  = 1;
  localparam int ALT_PCL_BIT  = 2;
  localparam int ALT_SER_BIT  = 3;

  // edge mode fields
  localparam int EDGE_SEL_LSB   = 0; // two bits, selectable edge input
  localparam int EDGE_NSYNC_BIT = 2; // 1: noise filter in sampled mode
  localparam int EDGE_ASYNC_BIT = 3; // async input: 0 rising, 1 falling
  localparam int EDGE_TEST_BIT  = 4; // test input: 0 rising, 1 falling

  // selectable edge encodings
  localparam logic [1:0] SEL_RISE = 2'h0;
  localparam logic [1:0] SEL_FALL = 2'h1;
  localparam logic [1:0] SEL_BOTH = 2'h2;
  localparam logic [1:0] SEL_OFF  = 2'h3;

  // interrupt status bit positions
  localparam int IRQ_DUAL_BIT = 0;
  localparam int IRQ_SEL_BIT  = 1;
  localparam int IRQ_ASYN_BIT = 2;
  localparam int IRQ_TEST_BIT = 3;
  localparam int IRQ_KEY_BIT  = 4;
  localparam int IRQ_W        = 5;

  // noise filter: samples that must agree
  localparam int NF_SAMPLES   = 3;
  localparam int NF_SLOW_DIV  = 4; // slow sampling divider ratio

  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
endpackage : mpc_pkg

// File: verilog/mpc_edge_filter.sv
// noise filter and edge detector for one synchronised pin
module mpc_edge_filter #(
  parameter int SAMPLES = 3
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic sample_en_i,
  input  wire logic filt_en_i,
  input  wire logic pin_i,
  output logic      rise_o,
  output logic      fall_o
);
  logic [SAMPLES-1:0] shift_reg;
  logic               level_reg;
  wire                all_one  = &shift_reg;
  wire                all_zero = ~|shift_reg;
  // filtered level only moves once every sample agrees
  wire                filt_lvl = all_one ? 1'b1 : (all_zero ? 1'b0 : level_reg);
  wire                new_lvl  = filt_en_i ? filt_lvl : pin_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_reg <= '0;
    end else if (sample_en_i) begin
      shift_reg <= {shift_reg[SAMPLES-2:0], pin_i};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_reg <= 1'b0;
    end else begin
      level_reg <= new_lvl;
    end
  end

  assign rise_o = new_lvl & ~level_reg;
  assign fall_o = ~new_lvl & level_reg;
endmodule : mpc_edge_filter

// File: verilog/mpc_port_ctrl.sv
// digital port pin control with ahb-lite register slave
// How it works
// [R01] input ports always readable, alternate use too
// [R02] pullups: port0 3-bit group, port1 4-bit group
// [R03] input ports in input mode at reset
// [R04] ports 2,5,7 whole-port direction; 3,6 per bit
// [R05] ports 6 and 7 as 8-bit pair
// [R06] pullups on ports 2,3,6,7 per port
// [R07] reset clears latches, ports input hi-z
// [R08] port 5 open drain, drives low only
// [R09] dual edge interrupt on port0 pin0
// [R10] port1 pin0 interrupt edge selectable
// [R11] port1 pin0 noise filter, sync or async
// [R12] falling edge on any key sets flag
// [R13] port1 pin3 feeds timer event pulses
// [R14] port2 carries square waves and clock out
// [R15] port0 pins 1-3 are serial pins
// [R16] software clears latch, sets output first
// [R17] test input edge sets test flag
// [R18] pins synchronised by two flip-flops
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
module mpc_port_ctrl (
  input  wire logic        CLOCK_I,
  input  wire logic        RST_N_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire logic [3:0]  P0_IN_I,
  input  wire logic [3:0]  P1_IN_I,
  input  wire logic [3:0]  P2_IN_I,
  input  wire logic [3:0]  P3_IN_I,
  input  wire logic [3:0]  P5_IN_I,
  input  wire logic [3:0]  P6_IN_I,
  input  wire logic [3:0]  P7_IN_I,
  output logic      [3:0]  P2_OUT_O,
  output logic      [3:0]  P2_OE_O,
  output logic      [3:0]  P3_OUT_O,
  output logic      [3:0]  P3_OE_O,
  output logic      [3:0]  P5_OUT_O,
  output logic      [3:0]  P5_OE_O,
  output logic      [3:0]  P6_OUT_O,
  output logic      [3:0]  P6_OE_O,
  output logic      [3:0]  P7_OUT_O,
  output logic      [3:0]  P7_OE_O,
  output logic      [2:0]  P0_PULLUP_O,
  output logic      [3:0]  P1_PULLUP_O,
  output logic      [3:0]  P2_PULLUP_O,
  output logic      [3:0]  P3_PULLUP_O,
  output logic      [3:0]  P6_PULLUP_O,
  output logic      [3:0]  P7_PULLUP_O,
  input  wire logic        TIMER_SQUARE_OUT_A_I,
  input  wire logic        TIMER_SQUARE_OUT_B_I,
  input  wire logic        PROG_CLOCK_OUT_I,
  output logic             EVENT_PULSE_O,
  input  wire logic        SER_CLK_OUT_I,
  input  wire logic        SER_CLK_OE_I,
  input  wire logic        SER_DATA_OUT_I,
  input  wire logic        SER_DATA_OE_I,
  output logic             SER_CLK_IN_O,
  output logic             SER_BUS_IN_O,
  output logic             SER_DATA_IN_O,
  output logic             SER_CLK_PIN_O,
  output logic             SER_CLK_PIN_OE_O,
  output logic             SERIAL_OUT_BUS_PIN_O,
  output logic             SERIAL_OUT_BUS_PIN_OE_O,
  output logic             IRQ_O
);
  // ---- synchronisers
  localparam int PW = 28;
  wire  [PW-1:0] pins_raw = {P7_IN_I, P6_IN_I, P5_IN_I, P3_IN_I, P2_IN_I, P1_IN_I, P0_IN_I};
  logic [PW-1:0] sync1_reg;
  logic [PW-1:0] sync2_reg;

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pins_raw;   // [R18]
      sync2_reg <= sync1_reg;  // [R18]
    end
  end

  wire [3:0] p0_s = sync2_reg[mpc_pkg::P0_LSB +: 4];
  wire [3:0] p1_s = sync2_reg[mpc_pkg::P1_LSB +: 4];
  wire [7:0] key_s = {sync2_reg[mpc_pkg::P7_LSB +: 4], sync2_reg[mpc_pkg::P6_LSB +: 4]};

  // ---- registers
  logic [19:0] latch_reg;
  logic [11:0] mode_reg;
  logic [5:0]  pullup_reg;
  logic [3:0]  alt_reg;
  logic [4:0]  edge_reg;
  logic [mpc_pkg::IRQ_W-1:0] stat_reg;
  logic [mpc_pkg::IRQ_W-1:0] mask_reg;

  // ---- ahb-lite slave, zero wait states
  logic       wr_pend_reg;
  logic [7:0] addr_reg;
  wire        xfer    = HSEL_I & HTRANS_I[1] & HREADY_I;
  wire        rd_take = xfer & ~HWRITE_I;
  wire [7:0]  ra      = HADDR_I[7:0];
  wire        wr_now  = wr_pend_reg;
  wire        wr_latch  = wr_now & (addr_reg == mpc_pkg::OFS_LATCH);
  wire        wr_mode   = wr_now & (addr_reg == mpc_pkg::OFS_MODE);
  wire        wr_pullup = wr_now & (addr_reg == mpc_pkg::OFS_PULLUP);
  wire        wr_alt    = wr_now & (addr_reg == mpc_pkg::OFS_ALT);
  wire        wr_edge   = wr_now & (addr_reg == mpc_pkg::OFS_EDGE);
  wire        wr_stat   = wr_now & (addr_reg == mpc_pkg::OFS_IRQ_STAT);
  wire        wr_mask   = wr_now & (addr_reg == mpc_pkg::OFS_IRQ_MASK);

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end else begin
      wr_pend_reg <= xfer & HWRITE_I;
      addr_reg    <= HADDR_I[7:0];
    end
  end

  // unmapped offsets read zero; response always okay
  wire [31:0] rd_mux =
    (ra == mpc_pkg::OFS_PORT_IN)  ? {4'h0, sync2_reg} :          // [R01]
    (ra == mpc_pkg::OFS_LATCH)    ? {12'h000, latch_reg} :
    (ra == mpc_pkg::OFS_MODE)     ? {20'h00000, mode_reg} :
    (ra == mpc_pkg::OFS_PULLUP)   ? {26'h0000000, pullup_reg} :
    (ra == mpc_pkg::OFS_ALT)      ? {28'h0000000, alt_reg} :
    (ra == mpc_pkg::OFS_EDGE)     ? {27'h0000000, edge_reg} :
    (ra == mpc_pkg::OFS_IRQ_STAT) ? {27'h0000000, stat_reg} :
    (ra == mpc_pkg::OFS_IRQ_MASK) ? {27'h0000000, mask_reg} : 32'h0000_0000;

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      HRDATA_O <= mpc_pkg::RST_ZERO;
    end else if (rd_take) begin
      HRDATA_O <= rd_mux;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      HREADYOUT_O <= 1'b0;
      HRESP_O     <= 1'b0;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end
  end

  // reset clears latches and puts everything in input mode
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      latch_reg  <= '0;  // [R07]
      mode_reg   <= '0;  // [R03] [R07]
      pullup_reg <= '0;
      alt_reg    <= '0;
      edge_reg   <= '0;
      mask_reg   <= '0;
    end else begin
      if (wr_latch)  latch_reg  <= HWDATA_I[19:0];
      if (wr_mode)   mode_reg   <= HWDATA_I[11:0];
      if (wr_pullup) pullup_reg <= HWDATA_I[5:0];
      if (wr_alt)    alt_reg    <= HWDATA_I[3:0];
      if (wr_edge)   edge_reg   <= HWDATA_I[4:0];
      if (wr_mask)   mask_reg   <= HWDATA_I[mpc_pkg::IRQ_W-1:0];
    end
  end

  // ---- direction decode
  wire       p67_pair = mode_reg[mpc_pkg::MODE_P67_BIT];
  wire [3:0] p2_dir = {4{mode_reg[mpc_pkg::MODE_P2_BIT]}};                         // [R04]
  wire [3:0] p5_dir = {4{mode_reg[mpc_pkg::MODE_P5_BIT]}};                         // [R04]
  wire [3:0] p3_dir = mode_reg[mpc_pkg::MODE_P3_LSB +: 4];                         // [R04]
  // pair mode overrides both halves with one direction
  wire [3:0] p6_dir = p67_pair ? 4'hF : mode_reg[mpc_pkg::MODE_P6_LSB +: 4];      // [R05] [R04]
  wire [3:0] p7_dir = {4{mode_reg[mpc_pkg::MODE_P7_BIT] | p67_pair}};             // [R05] [R04]

  // square waves and the clock out replace the latch on port 2 pins whose alt_reg enable is set; the latch and direction are not checked
  wire [3:0] p2_alt = {1'b0, PROG_CLOCK_OUT_I, TIMER_SQUARE_OUT_B_I, TIMER_SQUARE_OUT_A_I};
  wire [3:0] p2_sel = {1'b0, alt_reg[mpc_pkg::ALT_PCL_BIT], alt_reg[mpc_pkg::ALT_SQB_BIT],
                       alt_reg[mpc_pkg::ALT_SQA_BIT]};
  wire [3:0] p2_lat = latch_reg[3:0];
  wire [3:0] p2_val = (p2_sel & p2_alt) | (~p2_sel & p2_lat);  // [R14] [R16]
  wire [3:0] p3_lat = latch_reg[7:4];
  wire [3:0] p5_lat = latch_reg[11:8];
  wire [3:0] p6_lat = latch_reg[15:12];
  wire [3:0] p7_lat = latch_reg[19:16];

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      P2_OUT_O <= 4'h0;
      P2_OE_O  <= 4'h0;
      P3_OUT_O <= 4'h0;
      P3_OE_O  <= 4'h0;
      P5_OUT_O <= 4'h0;
      P5_OE_O  <= 4'h0;
      P6_OUT_O <= 4'h0;
      P6_OE_O  <= 4'h0;
      P7_OUT_O <= 4'h0;
      P7_OE_O  <= 4'h0;
    end else begin
      P2_OUT_O <= p2_val;
      P2_OE_O  <= p2_dir;
      P3_OUT_O <= p3_lat;
      P3_OE_O  <= p3_dir;
      P5_OUT_O <= 4'h0;              // [R08]
      P5_OE_O  <= p5_dir & ~p5_lat;  // [R08]
      P6_OUT_O <= p6_lat;
      P6_OE_O  <= p6_dir;
      P7_OUT_O <= p7_lat;
      P7_OE_O  <= p7_dir;
    end
  end

  // pullups act only on pins in input mode
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      P0_PULLUP_O <= 3'h0;
      P1_PULLUP_O <= 4'h0;
      P2_PULLUP_O <= 4'h0;
      P3_PULLUP_O <= 4'h0;
      P6_PULLUP_O <= 4'h0;
      P7_PULLUP_O <= 4'h0;
    end else begin
      P0_PULLUP_O <= {3{pullup_reg[mpc_pkg::PU_P0_BIT]}};            // [R02]
      P1_PULLUP_O <= {4{pullup_reg[mpc_pkg::PU_P1_BIT]}};            // [R02]
      P2_PULLUP_O <= {4{pullup_reg[mpc_pkg::PU_P2_BIT]}} & ~p2_dir;  // [R06]
      P3_PULLUP_O <= {4{pullup_reg[mpc_pkg::PU_P3_BIT]}} & ~p3_dir;  // [R06]
      P6_PULLUP_O <= {4{pullup_reg[mpc_pkg::PU_P6_BIT]}} & ~p6_dir;  // [R06]
      P7_PULLUP_O <= {4{pullup_reg[mpc_pkg::PU_P7_BIT]}} & ~p7_dir;  // [R06]
    end
  end

  // ---- serial pins on port 0, gated so reset leaves them inputs
  wire ser_en = alt_reg[mpc_pkg::ALT_SER_BIT];
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SER_CLK_IN_O            <= 1'b0;
      SER_BUS_IN_O            <= 1'b0;
      SER_DATA_IN_O           <= 1'b0;
      SER_CLK_PIN_O           <= 1'b0;
      SER_CLK_PIN_OE_O        <= 1'b0;
      SERIAL_OUT_BUS_PIN_O    <= 1'b0;
      SERIAL_OUT_BUS_PIN_OE_O <= 1'b0;
      EVENT_PULSE_O           <= 1'b0;
    end else begin
      SER_CLK_IN_O            <= p0_s[1];                  // [R15]
      SER_BUS_IN_O            <= p0_s[2];                  // [R15]
      SER_DATA_IN_O           <= p0_s[3];                  // [R15]
      SER_CLK_PIN_O           <= SER_CLK_OUT_I;            // [R15]
      SER_CLK_PIN_OE_O        <= ser_en & SER_CLK_OE_I;    // [R15]
      SERIAL_OUT_BUS_PIN_O    <= SER_DATA_OUT_I;           // [R15]
      SERIAL_OUT_BUS_PIN_OE_O <= ser_en & SER_DATA_OE_I;   // [R15]
      EVENT_PULSE_O           <= p1_s[3];                  // [R13]
    end
  end

  // ---- edge detection
  logic [3:0] prev_reg;
  logic [7:0] key_prev_reg;
  logic [1:0] div_reg;
  wire        slow_tick = (div_reg == 2'(mpc_pkg::NF_SLOW_DIV - 1));
  wire        sel_rise;
  wire        sel_fall;

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      prev_reg     <= 4'h0;
      key_prev_reg <= 8'h00;
      div_reg      <= 2'h0;
    end else begin
      prev_reg     <= {1'b0, p1_s[2], p1_s[1], p0_s[0]};
      key_prev_reg <= key_s;
      div_reg      <= slow_tick ? 2'h0 : div_reg + 2'h1;
    end
  end

  // filter trades latency for rejection of short glitches
  mpc_edge_filter #(
    .SAMPLES (mpc_pkg::NF_SAMPLES)
  ) u_sel_filter (
    .clk_i       (CLOCK_I),
    .rst_n_i     (RST_N_I),
    .sample_en_i (slow_tick),
    .filt_en_i   (edge_reg[mpc_pkg::EDGE_NSYNC_BIT]),  // [R11]
    .pin_i       (p1_s[0]),
    .rise_o      (sel_rise),
    .fall_o      (sel_fall)
  );

  wire [1:0] sel_mode = edge_reg[mpc_pkg::EDGE_SEL_LSB +: 2];
  wire ev_dual = p0_s[0] ^ prev_reg[0];                                      // [R09]
  wire ev_sel  = (sel_mode == mpc_pkg::SEL_RISE) ? sel_rise :
                 (sel_mode == mpc_pkg::SEL_FALL) ? sel_fall :
                 (sel_mode == mpc_pkg::SEL_BOTH) ? (sel_rise | sel_fall) : 1'b0;  // [R10]
  wire ev_asyn = edge_reg[mpc_pkg::EDGE_ASYNC_BIT] ? (~p1_s[1] & prev_reg[1])
                                                   : (p1_s[1] & ~prev_reg[1]);
  wire ev_test = edge_reg[mpc_pkg::EDGE_TEST_BIT] ? (~p1_s[2] & prev_reg[2])
                                                  : (p1_s[2] & ~prev_reg[2]);   // [R17]
  wire ev_key  = |(~key_s & key_prev_reg);                                   // [R12]
  wire [mpc_pkg::IRQ_W-1:0] events = {ev_key, ev_test, ev_asyn, ev_sel, ev_dual};
  wire [mpc_pkg::IRQ_W-1:0] clr    = wr_stat ? HWDATA_I[mpc_pkg::IRQ_W-1:0] : '0;

  // a new event wins over a same-cycle clear
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      stat_reg <= '0;
      IRQ_O    <= 1'b0;
    end else begin
      stat_reg <= (stat_reg & ~clr) | events;  // [R12] [R17]
      IRQ_O    <= |(((stat_reg & ~clr) | events) & mask_reg);
    end
  end
endmodule : mpc_port_ctrl

// File: testbench/mpc_port_ctrl_properties.sv
// checker for the port pin control block, bound to its top
module mpc_port_ctrl_chk (
  input wire logic       CLOCK_I,
  input wire logic       RST_N_I,
  input wire logic [3:0] P0_IN_I,
  input wire logic [3:0] P1_IN_I,
  input wire logic [3:0] P2_OE_O,
  input wire logic [3:0] P3_OE_O,
  input wire logic [3:0] P5_OUT_O,
  input wire logic [3:0] P6_OE_O,
  input wire logic [3:0] P7_OE_O,
  input wire logic [2:0] P0_PULLUP_O,
  input wire logic [3:0] P1_PULLUP_O,
  input wire logic [3:0] P2_PULLUP_O,
  input wire logic [3:0] P3_PULLUP_O,
  input wire logic [3:0] P6_PULLUP_O,
  input wire logic [3:0] P7_PULLUP_O,
  input wire logic       SER_CLK_IN_O,
  input wire logic       SER_DATA_IN_O,
  input wire logic       EVENT_PULSE_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);
  AST_P5_LOW_ONLY: assert property (P5_OUT_O == 4'h0)
    else $error("port 5 drove high");
  AST_P2_WHOLE_DIR: assert property (P2_OE_O inside {4'h0, 4'hF})
    else $error("port 2 direction split");
  AST_P7_WHOLE_DIR: assert property (P7_OE_O inside {4'h0, 4'hF})
    else $error("port 7 direction split");
  AST_P0_PU_GROUP: assert property (P0_PULLUP_O inside {3'h0, 3'h7})
    else $error("port 0 pullups split");
  AST_P1_PU_GROUP: assert property (P1_PULLUP_O inside {4'h0, 4'hF})
    else $error("port 1 pullups split");
  AST_P2_PU_INPUT: assert property ((P2_PULLUP_O & P2_OE_O) == 4'h0)
    else $error("port 2 pullup on output");
  AST_P3_PU_INPUT: assert property ((P3_PULLUP_O & P3_OE_O) == 4'h0)
    else $error("port 3 pullup on output");
  AST_P67_PU_INPUT: assert property (((P6_PULLUP_O & P6_OE_O) | (P7_PULLUP_O & P7_OE_O)) == 4'h0)
    else $error("port 6 or 7 pullup on output");
  AST_SER_DATA_SYNC: assert property (($stable(P0_IN_I[3]))[*4] |-> SER_DATA_IN_O == P0_IN_I[3])
    else $error("serial data input lags pin");
  AST_SER_CLK_SYNC: assert property (($stable(P0_IN_I[1]))[*4] |-> SER_CLK_IN_O == P0_IN_I[1])
    else $error("serial clock input lags pin");
  AST_EVENT_SYNC: assert property (($stable(P1_IN_I[3]))[*4] |-> EVENT_PULSE_O == P1_IN_I[3])
    else $error("event pulse lags pin");
endmodule : mpc_port_ctrl_chk

bind mpc_port_ctrl mpc_port_ctrl_chk chk_i (.*);

// File: testbench/mpc_board.sv
// board model: external drivers, pullups and floating pins
module mpc_board #(
  parameter logic P5_PU = 1'h1 // pull-up fitted on port 5
) (
  input  wire logic        CLOCK_I,
  input  wire logic [27:0] EXT_VAL_I,
  input  wire logic [27:0] EXT_DRV_I,
  input  wire logic [3:0]  P2_OUT_O,
  input  wire logic [3:0]  P2_OE_O,
  input  wire logic [3:0]  P3_OUT_O,
  input  wire logic [3:0]  P3_OE_O,
  input  wire logic [3:0]  P5_OE_O,
  input  wire logic [3:0]  P6_OUT_O,
  input  wire logic [3:0]  P6_OE_O,
  input  wire logic [3:0]  P7_OUT_O,
  input  wire logic [3:0]  P7_OE_O,
  input  wire logic [2:0]  P0_PULLUP_O,
  input  wire logic [3:0]  P1_PULLUP_O,
  input  wire logic [3:0]  P2_PULLUP_O,
  input  wire logic [3:0]  P3_PULLUP_O,
  input  wire logic [3:0]  P6_PULLUP_O,
  input  wire logic [3:0]  P7_PULLUP_O,
  output logic      [3:0]  P0_IN_I,
  output logic      [3:0]  P1_IN_I,
  output logic      [3:0]  P2_IN_I,
  output logic      [3:0]  P3_IN_I,
  output logic      [3:0]  P5_IN_I,
  output logic      [3:0]  P6_IN_I,
  output logic      [3:0]  P7_IN_I
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] flt = 4'h5;
  // undriven lines wander so a stale value never reads back
  always @(posedge CLOCK_I) flt <= ~flt;
  function automatic logic [3:0] lvl(input logic [3:0] oe, o, pu, v, d, f);
    for (int i = 0; i < 4; i++) lvl[i] = oe[i] ? o[i] : d[i] ? v[i] : pu[i] ? 1'h1 : f[i];
  endfunction : lvl
  assign P0_IN_I = lvl(4'h0, 4'h0, {P0_PULLUP_O, 1'h0}, EXT_VAL_I[3:0], EXT_DRV_I[3:0], flt);
  assign P1_IN_I = lvl(4'h0, 4'h0, P1_PULLUP_O, EXT_VAL_I[7:4], EXT_DRV_I[7:4], flt);
  assign P2_IN_I = lvl(P2_OE_O, P2_OUT_O, P2_PULLUP_O, EXT_VAL_I[11:8], EXT_DRV_I[11:8], flt);
  assign P3_IN_I = lvl(P3_OE_O, P3_OUT_O, P3_PULLUP_O, EXT_VAL_I[15:12], EXT_DRV_I[15:12], flt);
  assign P5_IN_I = lvl(P5_OE_O, 4'h0, {4{P5_PU}}, EXT_VAL_I[19:16], EXT_DRV_I[19:16], flt);
  assign P6_IN_I = lvl(P6_OE_O, P6_OUT_O, P6_PULLUP_O, EXT_VAL_I[23:20], EXT_DRV_I[23:20], flt);
  assign P7_IN_I = lvl(P7_OE_O, P7_OUT_O, P7_PULLUP_O, EXT_VAL_I[27:24], EXT_DRV_I[27:24], flt);
endmodule : mpc_board

// File: testbench/test_mcu_port_pin_control.sv
// self-checking bench for the port pin control block
module test_mcu_port_pin_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK_I = 1'h0, RST_N_I = 1'h0, HSEL_I = 1'h1, HWRITE_I = 1'h0, HREADY_I;
  logic [31:0] HADDR_I = 32'h0, HWDATA_I = 32'h0, HRDATA_O, rd;
  logic [1:0] HTRANS_I = 2'h0;
  logic [2:0] HSIZE_I = 3'h2, P0_PULLUP_O;
  logic HREADYOUT_O, HRESP_O, IRQ_O, EVENT_PULSE_O, SER_CLK_IN_O, SER_BUS_IN_O, SER_DATA_IN_O;
  logic SER_CLK_PIN_O, SER_CLK_PIN_OE_O, SERIAL_OUT_BUS_PIN_O, SERIAL_OUT_BUS_PIN_OE_O;
  logic [3:0] P0_IN_I, P1_IN_I, P2_IN_I, P3_IN_I, P5_IN_I, P6_IN_I, P7_IN_I;
  logic [3:0] P2_OUT_O, P2_OE_O, P3_OUT_O, P3_OE_O, P5_OUT_O, P5_OE_O, P6_OUT_O, P6_OE_O, P7_OUT_O, P7_OE_O;
  logic [3:0] P1_PULLUP_O, P2_PULLUP_O, P3_PULLUP_O, P6_PULLUP_O, P7_PULLUP_O;
  logic TIMER_SQUARE_OUT_A_I = 1'h0, TIMER_SQUARE_OUT_B_I = 1'h0, PROG_CLOCK_OUT_I = 1'h0;
  logic SER_CLK_OUT_I = 1'h0, SER_CLK_OE_I = 1'h0, SER_DATA_OUT_I = 1'h0, SER_DATA_OE_I = 1'h0;
  logic [27:0] EXT_VAL_I = 28'hFF00000, EXT_DRV_I = 28'hFF000FF;
  int n_fail = 0, n_compared = 0;
  assign HREADY_I = HREADYOUT_O;
  always #4 CLOCK_I = ~CLOCK_I;
  mpc_port_ctrl dut (.*);
  mpc_board brd (.*);

  task automatic wrap_up;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      $display("[ERR] %0t %s", $time, m);
      n_fail++;
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge CLOCK_I);
  endtask : wt
  task automatic hold;
    int k;
    k = 0;
    do begin
      @(posedge CLOCK_I);
      k++;
    end while (HREADYOUT_O !== 1'h1 && k < 64);
    if (HREADYOUT_O !== 1'h1) begin
      $display("[ERR] %0t bus hang", $time);
      n_fail++;
      wrap_up();
    end
  endtask : hold
  // address phase held until ready, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    HTRANS_I <= 2'h2;
    HWRITE_I <= w;
    HADDR_I <= {24'h0, a};
    hold();
    HTRANS_I <= 2'h0;
    HWDATA_I <= d;
    hold();
    rd = HRDATA_O;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(rd, e, "register read");
  endtask : rdc
  // one pin change, then level, flag and clear
  task automatic ev(input int p, input logic v, input int b, input logic e);
    EXT_VAL_I[p] <= v;
    wt(40);
    chk(IRQ_O, e, "irq level");
    bus(1'h0, mpc_pkg::OFS_IRQ_STAT, 32'h0);
    chk(rd, e ? 32'h1 << b : 32'h0, "event flag");
    wr(mpc_pkg::OFS_IRQ_STAT, 32'h1 << b);
    wt(3);
    chk(IRQ_O, 1'h0, "irq clear");
  endtask : ev

  task automatic t_reset;
    wt(4);
    chk({P2_OE_O, P3_OE_O, P5_OE_O, P6_OE_O, P7_OE_O}, 32'h0, "oe after reset");
    chk({P0_PULLUP_O, P1_PULLUP_O, P2_PULLUP_O, P3_PULLUP_O, P6_PULLUP_O, P7_PULLUP_O}, 32'h0, "pullups");
    rdc(mpc_pkg::OFS_LATCH, 32'h0);
    rdc(mpc_pkg::OFS_MODE, 32'h0);
    bus(1'h0, mpc_pkg::OFS_PORT_IN, 32'h0);
    chk(rd & 32'h0FFF00FF, 32'h0FFF0000, "pins after reset");
    wr(8'h40, 32'hFFFFFFFF);
    rdc(8'h40, 32'h0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_read;
    wr(mpc_pkg::OFS_ALT, 32'h8);
    SER_CLK_OE_I <= 1'h1;
    SER_CLK_OUT_I <= 1'h1;
    SER_DATA_OE_I <= 1'h1;
    EXT_VAL_I[7:0] <= 8'h5A;
    wt(5);
    bus(1'h0, mpc_pkg::OFS_PORT_IN, 32'h0);
    chk(rd & 32'hFF, 32'h5A, "input ports");
    chk({SER_CLK_IN_O, SER_BUS_IN_O, SER_DATA_IN_O, EVENT_PULSE_O}, 32'hA, "alt inputs");
    chk({SER_CLK_PIN_O, SER_CLK_PIN_OE_O, SERIAL_OUT_BUS_PIN_O, SERIAL_OUT_BUS_PIN_OE_O}, 32'hD, "ser");
    wr(mpc_pkg::OFS_ALT, 32'h0);
    EXT_VAL_I[7:0] <= 8'h00;
    wt(3);
    chk({SER_CLK_PIN_OE_O, SERIAL_OUT_BUS_PIN_OE_O}, 32'h0, "serial released");
    $display("t_read done");
  endtask : t_read
  task automatic t_pull;
    wr(mpc_pkg::OFS_PULLUP, 32'h3F);
    wt(2);
    chk({P0_PULLUP_O, P1_PULLUP_O, P2_PULLUP_O, P3_PULLUP_O, P6_PULLUP_O, P7_PULLUP_O}, 32'h7FFFFF, "pu");
    rdc(mpc_pkg::OFS_PULLUP, 32'h3F);
    wr(mpc_pkg::OFS_MODE, 32'h1);
    wt(2);
    chk({P2_PULLUP_O, P3_PULLUP_O}, 32'h0F, "pu on output");
    wr(mpc_pkg::OFS_PULLUP, 32'h0);
    $display("t_pull done");
  endtask : t_pull
  task automatic t_dir;
    wr(mpc_pkg::OFS_LATCH, 32'h9C5A3);
    wr(mpc_pkg::OFS_MODE, 32'h363);
    wt(2);
    chk({P2_OE_O, P3_OE_O, P5_OE_O, P6_OE_O, P7_OE_O}, 32'hF6A30, "direction");
    chk({P2_OUT_O, P3_OUT_O & P3_OE_O, P5_OUT_O, P6_OUT_O & P6_OE_O}, 32'h3200, "drive");
    wt(3);
    bus(1'h0, mpc_pkg::OFS_PORT_IN, 32'h0);
    chk(rd[19:16], 32'h5, "open drain pins");
    rdc(mpc_pkg::OFS_MODE, 32'h363);
    wr(mpc_pkg::OFS_MODE, 32'h8);
    wt(2);
    chk({P2_OE_O, P3_OE_O, P6_OE_O, P7_OE_O, P6_OUT_O, P7_OUT_O}, 32'h00FFC9, "pair");
    wr(mpc_pkg::OFS_MODE, 32'h0);
    $display("t_dir done");
  endtask : t_dir
  task automatic t_alt;
    wr(mpc_pkg::OFS_LATCH, 32'h0);
    wr(mpc_pkg::OFS_MODE, 32'h1);
    wr(mpc_pkg::OFS_ALT, 32'h7);
    TIMER_SQUARE_OUT_A_I <= 1'h1;
    PROG_CLOCK_OUT_I <= 1'h1;
    wt(3);
    chk(P2_OUT_O[2:0], 32'h5, "alt outputs");
    TIMER_SQUARE_OUT_A_I <= 1'h0;
    TIMER_SQUARE_OUT_B_I <= 1'h1;
    PROG_CLOCK_OUT_I <= 1'h0;
    wt(3);
    chk(P2_OUT_O[2:0], 32'h2, "alt outputs");
    wr(mpc_pkg::OFS_ALT, 32'h0);
    wr(mpc_pkg::OFS_MODE, 32'h0);
    $display("t_alt done");
  endtask : t_alt
  task automatic t_irq;
    wr(mpc_pkg::OFS_IRQ_MASK, 32'h1F);
    wr(mpc_pkg::OFS_IRQ_STAT, 32'h1F);
    ev(0, 1'h1, 0, 1'h1);
    ev(0, 1'h0, 0, 1'h1);
    for (int m = 0; m < 4; m++) begin
      wr(mpc_pkg::OFS_EDGE, m);
      ev(4, 1'h1, 1, m == 0 || m == 2);
      ev(4, 1'h0, 1, m == 1 || m == 2);
    end
    // short pulse passes only without the filter
    for (int f = 0; f < 2; f++) begin
      wr(mpc_pkg::OFS_EDGE, f << 2);
      EXT_VAL_I[4] <= 1'h1;
      wt(2);
      ev(4, 1'h0, 1, f == 0);
    end
    ev(4, 1'h1, 1, 1'h1);
    // async input: rising by default, then falling selected
    ev(5, 1'h1, 2, 1'h1);
    wr(mpc_pkg::OFS_EDGE, 32'h8);
    ev(5, 1'h0, 2, 1'h1);
    ev(6, 1'h1, 3, 1'h1);
    ev(6, 1'h0, 3, 1'h0);
    ev(20, 1'h0, 4, 1'h1);
    ev(20, 1'h1, 4, 1'h0);
    ev(27, 1'h0, 4, 1'h1);
    wr(mpc_pkg::OFS_IRQ_MASK, 32'h0);
    EXT_VAL_I[0] <= 1'h1;
    wt(40);
    chk(IRQ_O, 1'h0, "masked irq");
    rdc(mpc_pkg::OFS_IRQ_STAT, 32'h1);
    wr(mpc_pkg::OFS_IRQ_MASK, 32'h1);
    wt(3);
    chk(IRQ_O, 1'h1, "unmasked irq");
    $display("t_irq done");
  endtask : t_irq

  initial begin
    wt(12);
    RST_N_I <= 1'h1;
    t_reset();
    t_read();
    t_pull();
    t_dir();
    t_alt();
    t_irq();
    wrap_up();
  end
endmodule : test_mcu_port_pin_control
